// ===== uerr_pkg.sv
// Package with register map, field positions and constants of the USB error flag block.
// How it works
// R1 - Each error flag is masked by its enable; the results are ORed into one summary.
// R2 - A flag stays set until software writes one to it; zero leaves it.
// R3 - A flag is set on the very next edge after its fault is detected.
// R4 - The error flag register reads all zeros after reset.
// R5 - A bit stuffing violation sets bit 7 and rejects the packet.
// R6 - A descriptor fetch not granted in time sets bit 5.
// R7 - An oversize data packet sets bit 5 and is truncated in buffer memory.
// R8 - More than 16 idle bit times after end of packet sets bit 4.
// R9 - A data field not a whole number of bytes sets bit 3.
// R10 - A data checksum failure sets bit 2 and rejects the data packet.
// R11 - A token checksum failure sets bit 1 and rejects the token.
// R12 - A packet identifier check failure sets bit 0.
// R13 - Summary error is bit 1 of the main interrupt flags, set on any enabled error.
// R14 - The enable register holds one enable per flag at the same positions.
// R15 - Bit 6 of the flag register reads zero and ignores writes.
package uerr_pkg;
   localparam logic [11:0] ADDR_FLAGS = 12'h000;
   localparam logic [11:0] ADDR_ENABLES = 12'h004;
   localparam logic [11:0] ADDR_CLEAR = 12'h008;
   localparam logic [11:0] ADDR_MAIN_FLAGS = 12'h00c;
   localparam logic [11:0] ADDR_MAIN_ENABLES = 12'h010;
   localparam logic [11:0] ADDR_MAIN_CLEAR = 12'h014;
   localparam logic [11:0] ADDR_PACKET = 12'h018;
   localparam logic [11:0] ADDR_TURN_LIMIT = 12'h01c;
   localparam int BIT_STUFF = 7;
   localparam int BIT_BUFFER = 5;
   localparam int BIT_TURN = 4;
   localparam int BIT_PARTIAL = 3;
   localparam int BIT_DCRC = 2;
   localparam int BIT_TCRC = 1;
   localparam int BIT_PID = 0;
   localparam int BIT_MAIN_ERROR = 1;
   localparam logic [7:0] FLAG_MASK = 8'hbf;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam int TURN_LIMIT_BITS = 16;
   localparam int CLK_MHZ = 125;
   localparam int BIT_RATE_KHZ = 12000;
   // Cycles per full-speed bit time, rounded down but never below one.
   localparam int CYC_PER_BIT_RAW = (CLK_MHZ * 1000) / BIT_RATE_KHZ;
   localparam int CYC_PER_BIT = (CYC_PER_BIT_RAW < 1) ? 1 : CYC_PER_BIT_RAW;
   localparam logic [15:0] TURN_LIMIT_RESET = 16'(TURN_LIMIT_BITS * CYC_PER_BIT);
   typedef enum logic [2:0] {
      UERR_T_IDLE = 3'b001,
      UERR_T_WAIT = 3'b010,
      UERR_T_FAULT = 3'b100
   } uerr_turn_t;
endpackage

// ===== uerr_turn_if.sv
// Interface that carries the turnaround timer's controls and result.
`timescale 1ns/1ns
interface uerr_turn_if;
   logic eop;
   logic bus_active;
   logic [15:0] limit;
   logic timeout;
   modport timer (input eop, input bus_active, input limit, output timeout);
   modport owner (output eop, output bus_active, output limit, input timeout);
endinterface

// ===== uerr_turn_timer.sv
// Bus turnaround timer that flags a host that stays idle too long after end of packet.
`timescale 1ns/1ns
module uerr_turn_timer (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Timer port.
   uerr_turn_if.timer tif
);
   uerr_pkg::uerr_turn_t state_q, state_d;
   logic [15:0] count_q, count_d;
   logic timeout_q, timeout_d;

   always_comb begin
      state_d = state_q;
      count_d = count_q;
      timeout_d = 1'b0;
      case (state_q)
         uerr_pkg::UERR_T_IDLE: begin
            count_d = 16'h0000;
         end
         uerr_pkg::UERR_T_WAIT: begin
            count_d = count_q + 16'h0001;
            if (tif.bus_active) begin
               state_d = uerr_pkg::UERR_T_IDLE;
            end else if (count_q >= tif.limit) begin
               state_d = uerr_pkg::UERR_T_FAULT; // R8
               timeout_d = 1'b1;
            end
         end
         uerr_pkg::UERR_T_FAULT: begin
            count_d = 16'h0000;
            if (tif.bus_active) begin
               state_d = uerr_pkg::UERR_T_IDLE;
            end
         end
         default: begin
            state_d = uerr_pkg::UERR_T_IDLE;
         end
      endcase
      // A fresh end of packet always restarts the count from zero.
      if (tif.eop) begin
         state_d = uerr_pkg::UERR_T_WAIT; // R8
         count_d = 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= uerr_pkg::UERR_T_IDLE;
         count_q <= 16'h0000;
         timeout_q <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         timeout_q <= timeout_d;
      end
   end

   assign tif.timeout = timeout_q;

   a_timeout_after_limit: assert property (@(posedge clk) disable iff (!rst_n) // R8
      tif.timeout |-> $past(state_q) == uerr_pkg::UERR_T_WAIT && !$past(tif.bus_active)
      && $past(count_q) >= $past(tif.limit))
      else $error("Turnaround timeout without an idle wait.");
endmodule

// ===== uerr_flags.sv
// Top of the USB error flag block with its APB register slave.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
module uerr_flags (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fault detections from the packet engine, one-cycle pulses.
   input wire logic stuff_fault,
   input wire logic desc_late,
   input wire logic packet_oversize,
   input wire logic partial_byte,
   input wire logic data_crc_fault,
   input wire logic token_crc_fault,
   input wire logic pid_fault,
   // Bus activity seen by the turnaround timer.
   input wire logic eop_seen,
   input wire logic bus_active,
   // Results to the packet engine and interrupt controller.
   output logic reject_packet,
   output logic truncate_packet,
   output logic error_summary,
   output logic irq
);
   logic [7:0] flags_q, flags_d;
   logic [7:0] enables_q, enables_d;
   logic [7:0] main_flags_q, main_flags_d;
   logic [7:0] main_en_q, main_en_d;
   logic [15:0] limit_q, limit_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d;
   logic reject_d, truncate_d, summary_d, irq_d;
   logic [7:0] faults;
   logic [7:0] clear;
   logic [7:0] main_clear;
   logic wr, rd, mapped;
   uerr_turn_if tif ();

   assign tif.eop = eop_seen;
   assign tif.bus_active = bus_active;
   assign tif.limit = limit_q;

   uerr_turn_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tif(tif)
   );

   function automatic logic [31:0] widen8(input logic [7:0] v);
      return {24'h000000, v};
   endfunction

   // One wait state lets read data settle in a flop; a write lands on the ready edge.
   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && penable && !pwrite && !pready;

   always_comb begin
      faults = 8'h00;
      faults[uerr_pkg::BIT_STUFF] = stuff_fault; // R5
      faults[uerr_pkg::BIT_BUFFER] = desc_late || packet_oversize; // R6 R7
      faults[uerr_pkg::BIT_TURN] = tif.timeout; // R8
      faults[uerr_pkg::BIT_PARTIAL] = partial_byte; // R9
      faults[uerr_pkg::BIT_DCRC] = data_crc_fault; // R10
      faults[uerr_pkg::BIT_TCRC] = token_crc_fault; // R11
      faults[uerr_pkg::BIT_PID] = pid_fault; // R12
   end

   always_comb begin
      mapped = 1'b1;
      case (paddr)
         uerr_pkg::ADDR_FLAGS, uerr_pkg::ADDR_ENABLES, uerr_pkg::ADDR_CLEAR,
         uerr_pkg::ADDR_MAIN_FLAGS, uerr_pkg::ADDR_MAIN_ENABLES,
         uerr_pkg::ADDR_MAIN_CLEAR, uerr_pkg::ADDR_PACKET,
         uerr_pkg::ADDR_TURN_LIMIT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      clear = 8'h00;
      main_clear = 8'h00;
      enables_d = enables_q;
      main_en_d = main_en_q;
      limit_d = limit_q;
      if (wr) begin
         case (paddr)
            uerr_pkg::ADDR_FLAGS: clear = pwdata[7:0]; // R2
            uerr_pkg::ADDR_CLEAR: clear = pwdata[7:0]; // R2
            uerr_pkg::ADDR_ENABLES: enables_d = pwdata[7:0] & uerr_pkg::FLAG_MASK; // R14
            uerr_pkg::ADDR_MAIN_ENABLES: main_en_d = pwdata[7:0];
            uerr_pkg::ADDR_MAIN_CLEAR: main_clear = pwdata[7:0];
            uerr_pkg::ADDR_MAIN_FLAGS: main_clear = pwdata[7:0];
            uerr_pkg::ADDR_TURN_LIMIT: limit_d = pwdata[15:0];
            default: clear = 8'h00;
         endcase
      end
      // A fault in the clearing cycle wins, so no event is lost.
      flags_d = ((flags_q & ~clear) | faults) & uerr_pkg::FLAG_MASK; // R2 R3 R15
      main_flags_d = main_flags_q & ~main_clear;
      main_flags_d[uerr_pkg::BIT_MAIN_ERROR] = |(flags_d & enables_d); // R1 R13
   end

   always_comb begin
      prdata_d = 32'h00000000;
      if (rd) begin
         case (paddr)
            uerr_pkg::ADDR_FLAGS: prdata_d = widen8(flags_q);
            uerr_pkg::ADDR_ENABLES: prdata_d = widen8(enables_q);
            uerr_pkg::ADDR_MAIN_FLAGS: prdata_d = widen8(main_flags_q);
            uerr_pkg::ADDR_MAIN_ENABLES: prdata_d = widen8(main_en_q);
            uerr_pkg::ADDR_PACKET: prdata_d = {30'h00000000, truncate_packet, reject_packet};
            uerr_pkg::ADDR_TURN_LIMIT: prdata_d = {16'h0000, limit_q};
            default: prdata_d = 32'h00000000;
         endcase
      end
      pready_d = psel && penable && !pready;
      pslverr_d = psel && penable && !pready && !mapped;
      reject_d = stuff_fault || data_crc_fault || token_crc_fault; // R5 R10 R11
      truncate_d = packet_oversize; // R7
      summary_d = main_flags_d[uerr_pkg::BIT_MAIN_ERROR]; // R1
      irq_d = |(main_flags_d & main_en_d);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_q <= uerr_pkg::FLAGS_RESET; // R4
         enables_q <= uerr_pkg::ENABLES_RESET;
         main_flags_q <= 8'h00;
         main_en_q <= 8'h00;
         limit_q <= uerr_pkg::TURN_LIMIT_RESET;
      end else begin
         flags_q <= flags_d;
         enables_q <= enables_d;
         main_flags_q <= main_flags_d;
         main_en_q <= main_en_d;
         limit_q <= limit_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reject_packet <= 1'b0;
         truncate_packet <= 1'b0;
         error_summary <= 1'b0;
         irq <= 1'b0;
      end else begin
         reject_packet <= reject_d;
         truncate_packet <= truncate_d;
         error_summary <= summary_d;
         irq <= irq_d;
      end
   end

   // Every fault must show in its flag on the very next edge.
   a_stuff_sets_bit: assert property (@(posedge clk) disable iff (!rst_n) // R5
      stuff_fault |=> flags_q[7])
      else $error("Stuffing fault did not set bit 7.");

   a_buffer_sets_bit: assert property (@(posedge clk) disable iff (!rst_n) // R6
      (desc_late || packet_oversize) |=> flags_q[5])
      else $error("Buffer fault did not set bit 5.");

   a_oversize_truncates: assert property (@(posedge clk) disable iff (!rst_n) // R7
      packet_oversize |=> truncate_packet && flags_q[5])
      else $error("Oversize packet not truncated.");

   a_turn_sets_bit: assert property (@(posedge clk) disable iff (!rst_n) // R8
      tif.timeout |=> flags_q[4])
      else $error("Turnaround timeout did not set bit 4.");

   a_partial_sets_bit: assert property (@(posedge clk) disable iff (!rst_n) // R9
      partial_byte |=> flags_q[3])
      else $error("Partial byte field did not set bit 3.");

   a_dcrc_rejects: assert property (@(posedge clk) disable iff (!rst_n) // R10
      data_crc_fault |=> flags_q[2] && reject_packet)
      else $error("Data checksum fault not flagged and rejected.");

   a_tcrc_rejects: assert property (@(posedge clk) disable iff (!rst_n) // R11
      token_crc_fault |=> flags_q[1] && reject_packet)
      else $error("Token checksum fault not flagged and rejected.");

   a_pid_sets_bit: assert property (@(posedge clk) disable iff (!rst_n) // R12
      pid_fault |=> flags_q[0])
      else $error("Packet id fault did not set bit 0.");

   // A stray set would send software after a fault that never happened.
   a_stuff_no_stray: assert property (@(posedge clk) disable iff (!rst_n) // R5
      !flags_q[7] && !stuff_fault |=> !flags_q[7])
      else $error("Bit 7 set without a stuffing fault.");

   a_buffer_no_stray: assert property (@(posedge clk) disable iff (!rst_n) // R6
      !flags_q[5] && !desc_late && !packet_oversize |=> !flags_q[5])
      else $error("Bit 5 set without a buffer fault.");

   a_turn_no_stray: assert property (@(posedge clk) disable iff (!rst_n) // R8
      !flags_q[4] && !tif.timeout |=> !flags_q[4])
      else $error("Bit 4 set without a turnaround timeout.");

   a_partial_no_stray: assert property (@(posedge clk) disable iff (!rst_n) // R9
      !flags_q[3] && !partial_byte |=> !flags_q[3])
      else $error("Bit 3 set without a partial byte field.");

   a_dcrc_no_stray: assert property (@(posedge clk) disable iff (!rst_n) // R10
      !flags_q[2] && !data_crc_fault |=> !flags_q[2])
      else $error("Bit 2 set without a data checksum fault.");

   a_tcrc_no_stray: assert property (@(posedge clk) disable iff (!rst_n) // R11
      !flags_q[1] && !token_crc_fault |=> !flags_q[1])
      else $error("Bit 1 set without a token checksum fault.");

   a_pid_no_stray: assert property (@(posedge clk) disable iff (!rst_n) // R12
      !flags_q[0] && !pid_fault |=> !flags_q[0])
      else $error("Bit 0 set without a packet id fault.");

   a_reject_has_cause: assert property (@(posedge clk) disable iff (!rst_n) // R5 R10 R11
      reject_packet |-> $past(stuff_fault) || $past(data_crc_fault) || $past(token_crc_fault))
      else $error("Packet rejected without a fault.");

   a_truncate_has_cause: assert property (@(posedge clk) disable iff (!rst_n) // R7
      truncate_packet |-> $past(packet_oversize))
      else $error("Packet truncated without an oversize fault.");

   // Flags leave only through a write of one on the ready edge.
   a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n) // R2
      flags_q[7] && !(wr && (paddr == uerr_pkg::ADDR_CLEAR) && pwdata[7])
      && !(wr && (paddr == uerr_pkg::ADDR_FLAGS) && pwdata[7]) |=> flags_q[7])
      else $error("Stuffing flag dropped without a clear.");

   a_flags_kept: assert property (@(posedge clk) disable iff (!rst_n) // R2
      1'b1 |=> (flags_q & $past(flags_q) & ~$past(clear)) == ($past(flags_q) & ~$past(clear)))
      else $error("A flag dropped although its bit was written zero.");

   a_clear_takes: assert property (@(posedge clk) disable iff (!rst_n) // R2
      1'b1 |=> (flags_q & $past(clear) & ~$past(faults)) == 8'h00)
      else $error("A flag written with one did not clear.");

   a_clear_on_ready: assert property (@(posedge clk) disable iff (!rst_n) // R2
      clear != 8'h00 |-> psel && penable && pready)
      else $error("A flag cleared outside the ready edge.");

   a_ready_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      pready |=> !pready)
      else $error("Ready stood longer than one cycle.");

   a_error_with_ready: assert property (@(posedge clk) disable iff (!rst_n)
      pslverr |-> pready)
      else $error("Slave error shown without ready.");

   // The summary is live, so it must track the gated flags on every cycle.
   a_summary_gated: assert property (@(posedge clk) disable iff (!rst_n) // R1
      error_summary == |(flags_q & enables_q))
      else $error("Summary error does not match gated flags.");

   a_main_bit_summary: assert property (@(posedge clk) disable iff (!rst_n) // R13
      main_flags_q[uerr_pkg::BIT_MAIN_ERROR] == error_summary)
      else $error("Main error bit differs from the summary.");

   a_main_rest_zero: assert property (@(posedge clk) disable iff (!rst_n) // R13
      (main_flags_q & 8'hfd) == 8'h00)
      else $error("A main flag other than the error bit is set.");

   a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n) // R13
      irq == (error_summary && main_en_q[uerr_pkg::BIT_MAIN_ERROR]))
      else $error("Interrupt does not follow the enabled summary.");

   a_enable_bit6_zero: assert property (@(posedge clk) disable iff (!rst_n) // R14
      enables_q[6] == 1'b0)
      else $error("Unused enable bit 6 is set.");

   a_bit6_zero: assert property (@(posedge clk) disable iff (!rst_n) // R15
      flags_q[6] == 1'b0)
      else $error("Unused flag bit 6 is set.");

   // These watch the reset itself, so they carry no disable condition.
   a_reset_clears_flags: assert property (@(posedge clk) // R4
      !rst_n |=> flags_q == uerr_pkg::FLAGS_RESET && enables_q == uerr_pkg::ENABLES_RESET)
      else $error("Flags or enables not zero after reset.");

   a_reset_quiets_out: assert property (@(posedge clk) // R4
      !rst_n |=> !irq && !error_summary && !pready && !reject_packet)
      else $error("Outputs not quiet after reset.");
endmodule

// ===== uerr_host_model.sv
// Host side model that injects packet faults and answers after a set turnaround gap.
`timescale 1ns/1ns
module uerr_host_model (
   // Clock.
   input wire logic clk,
   // Commands from the bench.
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic [15:0] gap,
   // Packet engine side.
   output logic [6:0] faults,
   output logic eop_seen,
   output logic bus_active
);
   logic [15:0] cnt_q;
   initial begin
      faults = 7'h00;
      eop_seen = 1'b0;
      bus_active = 1'b0;
      cnt_q = 16'h0000;
   end
   // Kind seven ends a packet, and the host then stays idle for gap cycles before it answers.
   always @(posedge clk) begin
      faults <= (go && kind != 3'h7) ? 7'h01 << kind : 7'h00;
      eop_seen <= go && kind == 3'h7;
      bus_active <= cnt_q == 16'h0001;
      if (go && kind == 3'h7) begin
         cnt_q <= gap;
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end
endmodule

// ===== test_usb_error_status_flags.sv
// Self-checking bench of the USB error flag block driven by the host model.
`timescale 1ns/1ns
module test_usb_error_status_flags;
   localparam logic [11:0] FL = uerr_pkg::ADDR_FLAGS;
   localparam logic [11:0] EN = uerr_pkg::ADDR_ENABLES;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, reject_packet, truncate_packet, error_summary, irq;
   logic go = 1'b0;
   logic [2:0] kind = 3'h0;
   logic [15:0] gap = 16'h0000;
   logic [6:0] faults;
   logic eop_seen, bus_active, err;
   logic [31:0] rd;
   int error_cnt = 0;
   int compares = 0;
   initial begin
      forever #4 clk = ~clk;
   end
   uerr_flags u_uerr_flags (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stuff_fault(faults[6]), .desc_late(faults[5]),
      .packet_oversize(faults[4]), .partial_byte(faults[3]), .data_crc_fault(faults[2]),
      .token_crc_fault(faults[1]), .pid_fault(faults[0]), .eop_seen(eop_seen),
      .bus_active(bus_active), .reject_packet(reject_packet),
      .truncate_packet(truncate_packet), .error_summary(error_summary), .irq(irq));
   uerr_host_model u_uerr_host_model (.clk(clk), .go(go), .kind(kind), .gap(gap),
      .faults(faults), .eop_seen(eop_seen), .bus_active(bus_active));
   task automatic close_out();
      $display("Compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Each transfer starts one edge late so a strobe is never assigned twice in one step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(name, exp, rd);
   endtask
   task automatic fire(input logic [2:0] k, input logic [15:0] g);
      @(posedge clk);
      go <= 1'b1;
      kind <= k;
      gap <= g;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   function automatic logic [7:0] fbit(input int k);
      int pos [7] = '{0, 1, 2, 3, 5, 5, 7};
      return 8'h01 << pos[k];
   endfunction
   initial begin
      int k;
      logic [7:0] e;
      logic [7:0] en;
      void'($urandom(94));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      chk("summary", 32'h00000000, 32'(error_summary));
      rdchk("flags", FL, 32'h00000000);
      rdchk("enables", EN, 32'h00000000);
      rdchk("limit", uerr_pkg::ADDR_TURN_LIMIT, 32'h000000a0);
      apb(1'b0, 12'h020, 32'h00000000);
      chk("unmapped", 32'h00000001, 32'(err));
      apb(1'b1, uerr_pkg::ADDR_MAIN_ENABLES, 32'h00000002);
      // The second pass enables every source so that each one is seen raising the summary.
      for (int j = 0; j < 14; j++) begin
         k = j % 7;
         en = (j < 7) ? 8'($urandom) : 8'hff;
         e = fbit(k);
         apb(1'b1, EN, {24'h000000, en});
         rdchk("enables", EN, {24'h000000, en & 8'hbf});
         fire(3'(k), 16'h0000);
         chk("summary", 32'(|(e & en)), 32'(error_summary));
         chk("irq", 32'(|(e & en)), 32'(irq));
         chk("reject", 32'(k inside {1, 2, 6}), 32'(reject_packet));
         chk("truncate", 32'(k == 4), 32'(truncate_packet));
         rdchk("flags", FL, {24'h000000, e});
         rdchk("main", uerr_pkg::ADDR_MAIN_FLAGS, {30'h0, |(e & en), 1'b0});
         apb(1'b1, FL, {24'h000000, ~e});
         rdchk("held", FL, {24'h000000, e});
         apb(1'b1, (j % 2 == 1) ? uerr_pkg::ADDR_CLEAR : FL, {24'h000000, e | 8'h40});
         rdchk("cleared", FL, 32'h00000000);
      end
      fire(3'h0, 16'h0000);
      fire(3'h1, 16'h0000);
      apb(1'b1, FL, 32'h00000001);
      rdchk("partial", FL, 32'h00000002);
      apb(1'b1, FL, 32'h00000002);
      fire(3'h7, 16'h0096);
      repeat (250) @(posedge clk);
      rdchk("answered", FL, 32'h00000000);
      fire(3'h7, 16'h00c8);
      repeat (250) @(posedge clk);
      rdchk("timeout", FL, 32'h00000010);
      chk("irq", 32'h00000001, 32'(irq));
      apb(1'b1, uerr_pkg::ADDR_MAIN_ENABLES, 32'h00000000);
      repeat (2) @(posedge clk);
      chk("masked", 32'h00000000, 32'(irq));
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk("flags", FL, 32'h00000000);
      rdchk("enables", EN, 32'h00000000);
      chk("irq", 32'h00000000, 32'(irq));
      close_out();
   end
endmodule
